// ---- core/sgl_cfg.svh ----
`ifndef SGL_CFG_SVH
`define SGL_CFG_SVH
`define SGL_CODE_BITS   8
`define SGL_CODE_RESET  8'h00
`define SGL_MASTER_RESET 1'b0
`define SGL_PD_OFF_NS   45
`define SGL_CLK_NS      40
`define SGL_GAIN_STEP_MILLI   16'h004d
`define SGL_GAIN_OFFS_MILLI   16'h013c
`define SGL_PIN_COUNT   4
`define SGL_PIN_DATA    0
`define SGL_PIN_SCK     1
`define SGL_PIN_WIN     2
`define SGL_PIN_SLEEP   3
`define SGL_PIN_IDLE    4'hc
`endif

// ---- core/sgl_pkg.sv ----
`include "sgl_cfg.svh"
package sgl_pkg;
  typedef logic [`SGL_CODE_BITS-1:0] sgl_code_t;
  typedef enum logic {SGL_AMP_SLEEP, SGL_AMP_FWD} sgl_mode_e;
endpackage : sgl_pkg

// ---- core/sgl_gain_loader.sv ----
// Contract
// - three host-driven inputs: serial data, load window low, serial clock.
// - gain code is eight bits, 256 settings.
// - code arrives msb first, one bit per serial clock rise.
// - while window low, applied gain keeps the previous code.
// - window rise after eight clocks applies the shifted code.
// - window rise stops further shifting.
// - code is unsigned 0..255, gain 0.316 plus 0.077 per step.
// - sleep input high: forward mode, output amplifier on.
// - sleep input low: amplifier off, forward output off, reverse stage on.
// - sleep leaves applied gain and input stage untouched.
// - bit taken in master on rise, moved to slave on fall.
// - window fall holds gain and enables shifting.
// - sleep acts any time, output off within 45 ns, gain kept; the logic takes three 40 ns clocks from the pin.
`timescale 1ns/1ns
`include "sgl_cfg.svh"
module sgl_gain_loader #(
  parameter int CODE_BITS = `SGL_CODE_BITS
) (
  input  wire logic                 clock,
  input  wire logic                 resetn,
  input  wire logic                 serial_gain_in,
  input  wire logic                 serial_clk,
  input  wire logic                 load_window_n,
  input  wire logic                 amp_sleep_n,
  output logic      [CODE_BITS-1:0] gain_code,
  output logic      [15:0]          gain_milli,
  output logic                      fwd_amp_en,
  output logic                      fwd_out_en,
  output logic                      rev_amp_en,
  output logic                      shift_en
);
  import sgl_pkg::*;

  // pins that cross into the clock domain, and their levels while idle
  localparam int              PINS     = `SGL_PIN_COUNT;
  localparam logic [PINS-1:0] PIN_IDLE = `SGL_PIN_IDLE;
  // clocks allowed from a synchronised sleep request to the amplifier going off
  localparam int              PD_CYC   = (`SGL_PD_OFF_NS / `SGL_CLK_NS) < 1 ? 1 :
                                         (`SGL_PD_OFF_NS / `SGL_CLK_NS);

  // shifter, latch and gain arithmetic are built for one code width only
  if (CODE_BITS != `SGL_CODE_BITS) begin : g_bad_width
    $error("code width must be eight");
  end

  // gain in thousandths of a volt per volt, code read as unsigned
  function automatic logic [15:0] gain_to_milli(input logic [CODE_BITS-1:0] code);
    return 16'(`SGL_GAIN_OFFS_MILLI) + 16'(`SGL_GAIN_STEP_MILLI) * 16'(code);
  endfunction : gain_to_milli

  // forward mode decode shared by the three amplifier enables
  function automatic logic is_forward(input sgl_mode_e mode);
    return mode == SGL_AMP_FWD;
  endfunction : is_forward

  // gain shown while reset holds the reset code
  localparam logic [15:0] MILLI_AT_RESET = gain_to_milli(`SGL_CODE_RESET);

  // raw pins gathered into one vector, bit positions named in the config header
  logic [PINS-1:0] pin_raw;
  always_comb begin
    pin_raw                 = '0;
    pin_raw[`SGL_PIN_DATA]  = serial_gain_in;
    pin_raw[`SGL_PIN_SCK]   = serial_clk;
    pin_raw[`SGL_PIN_WIN]   = load_window_n;
    pin_raw[`SGL_PIN_SLEEP] = amp_sleep_n;
  end

  // per pin: two synchroniser stages, then one delay stage for edge finding
  // reset loads each pin's idle level so that no false edge follows reset
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] pin_last;
  for (genvar p = 0; p < PINS; p++) begin : g_sync
    logic meta_ff;
    logic sync_ff;
    logic last_ff;
    logic nxt_meta;
    logic nxt_sync;
    logic nxt_last;
    // only the second stage reads the first
    always_comb begin
      nxt_meta = pin_raw[p];
      nxt_sync = meta_ff;
      nxt_last = sync_ff;
    end
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        meta_ff <= PIN_IDLE[p];
        sync_ff <= PIN_IDLE[p];
        last_ff <= PIN_IDLE[p];
      end else begin
        meta_ff <= nxt_meta;
        sync_ff <= nxt_sync;
        last_ff <= nxt_last;
      end
    end
    assign pin_sync[p] = sync_ff;
    assign pin_last[p] = last_ff;
  end

  // synchronised levels and the serial clock and window edges
  logic sdat;
  logic sck_r;
  logic sck_f;
  logic win_n;
  logic win_r;
  logic sleep_n;
  always_comb begin
    sdat    = pin_sync[`SGL_PIN_DATA];
    sck_r   = pin_sync[`SGL_PIN_SCK] & ~pin_last[`SGL_PIN_SCK];
    sck_f   = ~pin_sync[`SGL_PIN_SCK] & pin_last[`SGL_PIN_SCK];
    win_n   = pin_sync[`SGL_PIN_WIN];
    win_r   = pin_sync[`SGL_PIN_WIN] & ~pin_last[`SGL_PIN_WIN];
    sleep_n = pin_sync[`SGL_PIN_SLEEP];
  end

  // master takes data on a serial rise, the shifter takes the master on a fall,
  // both only while the window is open; a window rise copies shifter to latch
  logic                 master_ff;
  logic                 nxt_master;
  logic [CODE_BITS-1:0] shreg_ff;
  logic [CODE_BITS-1:0] nxt_shreg;
  logic [CODE_BITS-1:0] code_ff;
  logic [CODE_BITS-1:0] nxt_code;
  always_comb begin
    nxt_master = master_ff;
    nxt_shreg  = shreg_ff;
    nxt_code   = code_ff;
    // a closed window gates both serial edges, so stray clocks do nothing
    if (!win_n && sck_r) begin
      nxt_master = sdat;
    end
    if (!win_n && sck_f) begin
      nxt_shreg = {shreg_ff[CODE_BITS-2:0], master_ff};
    end
    // the latch stays closed except at the window's rise
    if (win_r) begin
      nxt_code = shreg_ff;
    end
  end
  // shifter and latch registers; the latch keeps its code through sleep
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      master_ff <= `SGL_MASTER_RESET;
      shreg_ff  <= `SGL_CODE_RESET;
      code_ff   <= `SGL_CODE_RESET;
    end else begin
      master_ff <= nxt_master;
      shreg_ff  <= nxt_shreg;
      code_ff   <= nxt_code;
    end
  end

  // amplifier mode follows the synchronised sleep pin at any time
  // three clocks from the pin: the price of synchronising an asynchronous input
  sgl_mode_e mode_ff;
  sgl_mode_e nxt_mode;
  always_comb begin
    nxt_mode = sleep_n ? SGL_AMP_FWD : SGL_AMP_SLEEP;
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= SGL_AMP_FWD;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // gain in thousandths, one clock behind the applied code
  logic [15:0] gm_ff;
  logic [15:0] nxt_gm;
  always_comb begin
    nxt_gm = gain_to_milli(code_ff);
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gm_ff <= MILLI_AT_RESET;
    end else begin
      gm_ff <= nxt_gm;
    end
  end

  // outputs: latch and gain from registers, amplifier enables decoded from the mode, shift enable from the window
  assign gain_code  = code_ff;
  assign gain_milli = gm_ff;
  assign fwd_amp_en = is_forward(mode_ff);
  assign fwd_out_en = is_forward(mode_ff);
  assign rev_amp_en = !is_forward(mode_ff);
  assign shift_en   = !win_n;

  // steps of one load: window fall, serial rise and fall inside it, window rise
  sequence s_window_open;
    $fell(win_n);
  endsequence
  sequence s_rise_in_window;
    !win_n && sck_r;
  endsequence
  sequence s_fall_in_window;
    !win_n && sck_f;
  endsequence
  sequence s_window_close;
    win_r;
  endsequence

  // latch: held while the window is open, loaded only at its rise
  chk_gain_hold: assert property (@(posedge clock) disable iff (!resetn)
    (!win_r) |=> $stable(code_ff)) else $error("gain changed without window rise");
  chk_gain_apply: assert property (@(posedge clock) disable iff (!resetn)
    s_window_close |=> (code_ff == $past(shreg_ff))) else $error("gain not applied");
  chk_window_open: assert property (@(posedge clock) disable iff (!resetn)
    s_window_open |-> shift_en) else $error("shifting not enabled");

  // shifter: still while the window is closed, one bit per serial fall otherwise
  chk_shift_idle: assert property (@(posedge clock) disable iff (!resetn)
    win_n |=> $stable(shreg_ff)) else $error("shift while window high");
  chk_shift_step: assert property (@(posedge clock) disable iff (!resetn)
    s_fall_in_window |=> (shreg_ff[0] == $past(master_ff))) else $error("bad shift");
  chk_shift_move: assert property (@(posedge clock) disable iff (!resetn)
    s_fall_in_window |=> (shreg_ff[CODE_BITS-1:1] == $past(shreg_ff[CODE_BITS-2:0])))
    else $error("shift not towards msb");
  chk_master_cap: assert property (@(posedge clock) disable iff (!resetn)
    s_rise_in_window |=> (master_ff == $past(sdat))) else $error("bad capture");

  // amplifier mode and the gain it keeps
  chk_sleep_off: assert property (@(posedge clock) disable iff (!resetn)
    !sleep_n |-> ##[1:PD_CYC] !fwd_amp_en) else $error("sleep too slow");
  chk_fwd_on: assert property (@(posedge clock) disable iff (!resetn)
    sleep_n |=> (fwd_amp_en && !rev_amp_en)) else $error("forward mode wrong");
  chk_rev_on: assert property (@(posedge clock) disable iff (!resetn)
    !fwd_amp_en |-> (rev_amp_en && !fwd_out_en)) else $error("reverse mode wrong");
  chk_sleep_gain: assert property (@(posedge clock) disable iff (!resetn)
    (!sleep_n && !win_r) |=> $stable(code_ff)) else $error("sleep changed gain");

  // gain arithmetic, one clock behind the code
  chk_gain_calc: assert property (@(posedge clock) disable iff (!resetn)
    1'b1 |=> (gm_ff == `SGL_GAIN_OFFS_MILLI + `SGL_GAIN_STEP_MILLI * 16'($past(code_ff))))
    else $error("gain calc");
endmodule : sgl_gain_loader

// ---- dv/sgl_host.sv ----
`timescale 1ns/1ns
// host side of the three-wire gain port; it only drives, the device only listens
module sgl_host (
  input  wire logic clock,
  output logic      serial_gain_in,
  output logic      serial_clk,
  output logic      load_window_n
);
  // idle lines at time zero, window closed
  initial begin
    serial_gain_in = 1'b0;
    serial_clk     = 1'b0;
    load_window_n  = 1'b1;
  end
  // pulse the serial clock, four system clocks per phase, off the falling edge
  task automatic pulse();
    repeat (4) @(negedge clock);
    serial_clk = 1'b1;
    repeat (4) @(negedge clock);
    serial_clk = 1'b0;
  endtask : pulse
  // one frame: window low, eight bits msb first, then window high
  task automatic send(input logic [7:0] code);
    load_window_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      serial_gain_in = code[i];
      pulse();
    end
    repeat (4) @(negedge clock);
    load_window_n  = 1'b1;
    serial_gain_in = ~code[0]; // released data line shows the inverse of its last bit
  endtask : send
  // four stray clocks with the window high, data set from the next argument bit each pulse
  task automatic stray(input logic [3:0] bits);
    for (int i = 0; i < 4; i++) begin
      serial_gain_in = bits[i];
      pulse();
    end
  endtask : stray
endmodule : sgl_host

// ---- dv/test_serial_gain_word_loader.sv ----
`timescale 1ns/1ns
module test_serial_gain_word_loader;
  import sgl_pkg::*;
  logic        clock = 1'b0, resetn = 1'b0, amp_sleep_n = 1'b1;
  logic        sd, sck, win_n, fwd_amp_en, fwd_out_en, rev_amp_en, shift_en;
  sgl_code_t   gain_code, code, prev;
  logic [15:0] gain_milli;
  logic [31:0] seed = 32'he1ce_9bf5;
  int          mismatches = 0, compares = 0;
  // 25 MHz system clock
  always #20 clock = ~clock;
  sgl_host sgl_host_inst (.clock(clock), .serial_gain_in(sd), .serial_clk(sck),
    .load_window_n(win_n));
  sgl_gain_loader sgl_gain_loader_inst (.clock(clock), .resetn(resetn), .serial_gain_in(sd),
    .serial_clk(sck), .load_window_n(win_n), .amp_sleep_n(amp_sleep_n), .gain_code(gain_code),
    .gain_milli(gain_milli), .fwd_amp_en(fwd_amp_en), .fwd_out_en(fwd_out_en),
    .rev_amp_en(rev_amp_en), .shift_en(shift_en));
  // xorshift step and expected gain in thousandths
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [15:0] milli(input logic [7:0] c);
    return 16'h013c + 16'h004d * {8'h00, c};
  endfunction : milli
  // compare one result, count it, report a mismatch
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // verdict and end of run
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // reset, then full-scale, zero and random frames with stray clocks between and sleep after every other frame
  initial begin
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    chk("gain_code", 16'h0000, gain_code);
    chk("gain_milli", milli(8'h00), gain_milli);
    chk("fwd_amp_en", 16'h0001, fwd_amp_en);
    repeat (3) @(negedge clock);
    for (int n = 0; n < 10; n++) begin
      seed = xs(seed);
      code = (n == 0) ? 8'hff : (n == 1) ? 8'h00 : seed[7:0];
      prev = gain_code;
      fork
        sgl_host_inst.send(code);
        begin
          repeat (40) @(negedge clock);
          chk("shift_en", 16'h0001, shift_en);
          chk("held gain_code", prev, gain_code);
        end
      join
      repeat (6) @(negedge clock);
      chk("gain_code", code, gain_code);
      chk("gain_milli", milli(code), gain_milli);
      chk("shift_en", 16'h0000, shift_en);
      sgl_host_inst.stray(seed[11:8]);
      repeat (6) @(negedge clock);
      chk("stray gain_code", code, gain_code);
      amp_sleep_n = n[0];
      repeat (4) @(negedge clock);
      chk("fwd_amp_en", {15'h0000, n[0]}, fwd_amp_en);
      chk("fwd_out_en", {15'h0000, n[0]}, fwd_out_en);
      chk("rev_amp_en", {15'h0000, ~n[0]}, rev_amp_en);
      chk("sleep gain_code", code, gain_code);
      amp_sleep_n = 1'b1;
      repeat (4) @(negedge clock);
      chk("fwd_amp_en", 16'h0001, fwd_amp_en);
    end
    wrap_up();
  end
endmodule : test_serial_gain_word_loader
